/* File: logic/pmc_cmd_handler.sv */
// Command handler: settings, run control, margining and telemetry readback
//
// Notes on behaviour
// - Run control bit 7 turns output on
// - Config low five bits, only bit 3 writable
// - Command-respond low means on bit ignored
// - Power-up rule: pin and command both per config
// - Pin-required bit demands asserted on/off pin
// - Turn-on/off thresholds 32 to 46 V, 0.125 V
// - Threshold words exponent -3, mantissa top zero
// - Start delay 10 to 500 ms, 0.5 ms
// - Ramp time 15 to 500 ms, 0.5 ms
// - Time words exponent -1, non-negative mantissa
// - Setpoint unsigned, exponent -12 reported in mode
// - Setpoint limited 8.10 to 13.20 V
// - Margin levels use exponent -12 too
// - Run control bits 5..2 select margining
// - Output reading unsigned, exponent -12
// - Output reading is raw plus offset cal
// - Input reading exponent -3, non-negative
// - Input offset cal readable, exponent -3
// - Input gain cal readable, unsigned 16 bit
// - Store to non-volatile only on store command
`timescale 1ns/10ps
`default_nettype none
module pmc_cmd_handler (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire logic [7:0] cmd_code_i,
	input wire logic [15:0] cmd_wdata_i,
	input wire logic onoff_pin_i,
	input wire logic [15:0] vout_adc_i,
	input wire logic [10:0] vin_adc_i,
	input wire logic [15:0] vout_offset_cal_i,
	input wire logic [15:0] vin_offset_cal_i,
	input wire logic [15:0] vin_gain_cal_i,
	output logic rsp_valid_o,
	output logic [15:0] rsp_rdata_o,
	output logic rsp_reject_o,
	output logic output_enable_o,
	output logic [15:0] target_vout_o,
	output logic margin_active_o,
	output logic [15:0] on_thresh_o,
	output logic [15:0] off_thresh_o,
	output logic [15:0] delay_time_o,
	output logic [15:0] ramp_time_o,
	output logic nvm_store_o
);
	import pmc_pkg::*;

	logic [7:0] run_ctrl_q;
	logic cmd_respond_q;
	logic [15:0] on_th_q, off_th_q, delay_q, ramp_q;
	logic [15:0] setpt_q, mhi_q, mlo_q;
	logic wr;
	logic accept;
	logic [15:0] rd;
	logic known;
	logic [4:0] cfg;
	logic [10:0] m;
	logic exp_uvlo_ok, exp_time_ok;
	logic [15:0] vout_corr;
	logic pin_on, bus_on, run_d;
	logic [15:0] tgt_d;
	logic [3:0] mg;

	assign wr = cmd_valid_i & cmd_write_i;
	assign m = cmd_wdata_i[EXP_LO-1:0];
	assign exp_uvlo_ok = cmd_wdata_i[EXP_HI:EXP_LO] == EXP_UVLO
		&& !cmd_wdata_i[MANT_SIGN];
	assign exp_time_ok = cmd_wdata_i[EXP_HI:EXP_LO] == EXP_TIME
		&& !cmd_wdata_i[MANT_SIGN];
	// Fixed read-only bits sit beside the one writable bit
	assign cfg = {SWITCH_CONFIG_RST[4], cmd_respond_q,
		SWITCH_CONFIG_RST[2:0]};

	// Range and format check; bad writes leave the setting alone
	always_comb begin
		accept = 1'b0;
		unique case (cmd_code_i)
			CMD_OUTPUT_RUN_CONTROL: accept = 1'b1;
			CMD_POWER_SWITCH_CONFIG: accept = 1'b1;
			CMD_STORE_DEFAULT_ALL: accept = 1'b1;
			CMD_INPUT_TURN_ON_THRESHOLD,
			CMD_INPUT_TURN_OFF_THRESHOLD: begin
				accept = exp_uvlo_ok && m >= UVLO_MIN && m <= UVLO_MAX;
			end
			CMD_STARTUP_DELAY_TIME: begin
				accept = exp_time_ok && m >= DELAY_MIN && m <= TIME_MAX;
			end
			CMD_STARTUP_RAMP_TIME: begin
				accept = exp_time_ok && m >= RAMP_MIN && m <= TIME_MAX;
			end
			CMD_OUTPUT_SETPOINT: begin
				accept = cmd_wdata_i >= SETPOINT_MIN
					&& cmd_wdata_i <= SETPOINT_MAX;
			end
			CMD_MARGIN_UPPER_LEVEL, CMD_MARGIN_LOWER_LEVEL: accept = 1'b1;
			default: accept = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			run_ctrl_q <= RUN_CONTROL_RST;
		end else if (wr && accept && cmd_code_i == CMD_OUTPUT_RUN_CONTROL) begin
			run_ctrl_q <= cmd_wdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_respond_q <= SWITCH_CONFIG_RST[CMD_RESPOND_BIT];
		end else if (wr && cmd_code_i == CMD_POWER_SWITCH_CONFIG) begin
			cmd_respond_q <= cmd_wdata_i[CMD_RESPOND_BIT];
		end
	end

	property p_cfg_keep;
		@(posedge clk_i) disable iff (!reset_n_i)
		wr && cmd_code_i == CMD_POWER_SWITCH_CONFIG
		|=> cmd_respond_q == $past(cmd_wdata_i[CMD_RESPOND_BIT])
		&& cfg[POWER_UP_RULE_BIT] && cfg[PIN_REQUIRED_BIT]
		&& cfg[PIN_POLARITY_BIT] && cfg[PIN_ACTION_BIT];
	endproperty
	a_cfg_keep: assert property (p_cfg_keep)
		else $error("Config write changed a fixed bit");

	// The host owns the hysteresis spacing, so it is not enforced here
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			on_th_q <= ON_THRESH_RST;
			off_th_q <= OFF_THRESH_RST;
			delay_q <= DELAY_RST;
			ramp_q <= RAMP_RST;
		end else if (wr && accept) begin
			if (cmd_code_i == CMD_INPUT_TURN_ON_THRESHOLD)
				on_th_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_INPUT_TURN_OFF_THRESHOLD)
				off_th_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_STARTUP_DELAY_TIME)
				delay_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_STARTUP_RAMP_TIME)
				ramp_q <= cmd_wdata_i;
		end
	end

	property p_uvlo_fmt;
		@(posedge clk_i) disable iff (!reset_n_i)
		on_th_q[EXP_HI:EXP_LO] == EXP_UVLO && !on_th_q[MANT_SIGN];
	endproperty
	a_uvlo_fmt: assert property (p_uvlo_fmt)
		else $error("Threshold format broken");

	property p_off_fmt;
		@(posedge clk_i) disable iff (!reset_n_i)
		off_th_q[EXP_HI:EXP_LO] == EXP_UVLO
		&& off_th_q[EXP_LO-1:0] >= UVLO_MIN
		&& off_th_q[EXP_LO-1:0] <= UVLO_MAX;
	endproperty
	a_off_fmt: assert property (p_off_fmt)
		else $error("Turn-off threshold out of range");

	property p_time_fmt;
		@(posedge clk_i) disable iff (!reset_n_i)
		delay_q[EXP_HI:EXP_LO] == EXP_TIME
		&& delay_q[EXP_LO-1:0] >= DELAY_MIN
		&& delay_q[EXP_LO-1:0] <= TIME_MAX;
	endproperty
	a_time_fmt: assert property (p_time_fmt)
		else $error("Delay out of range");

	property p_ramp_fmt;
		@(posedge clk_i) disable iff (!reset_n_i)
		ramp_q[EXP_HI:EXP_LO] == EXP_TIME
		&& ramp_q[EXP_LO-1:0] >= RAMP_MIN
		&& ramp_q[EXP_LO-1:0] <= TIME_MAX;
	endproperty
	a_ramp_fmt: assert property (p_ramp_fmt)
		else $error("Ramp time format broken");

	property p_uvlo_reject;
		@(posedge clk_i) disable iff (!reset_n_i)
		wr && !accept && cmd_code_i == CMD_INPUT_TURN_ON_THRESHOLD
		|=> $stable(on_th_q) && rsp_reject_o;
	endproperty
	a_uvlo_reject: assert property (p_uvlo_reject)
		else $error("Bad threshold stored");

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			setpt_q <= SETPOINT_RST;
			mhi_q <= MARGIN_UP_RST;
			mlo_q <= MARGIN_DN_RST;
		end else if (wr && accept) begin
			if (cmd_code_i == CMD_OUTPUT_SETPOINT)
				setpt_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_MARGIN_UPPER_LEVEL)
				mhi_q <= cmd_wdata_i;
			if (cmd_code_i == CMD_MARGIN_LOWER_LEVEL)
				mlo_q <= cmd_wdata_i;
		end
	end

	property p_setpt_rng;
		@(posedge clk_i) disable iff (!reset_n_i)
		setpt_q >= SETPOINT_MIN && setpt_q <= SETPOINT_MAX;
	endproperty
	a_setpt_rng: assert property (p_setpt_rng)
		else $error("Setpoint out of range");

	property p_reject;
		@(posedge clk_i) disable iff (!reset_n_i)
		wr && !accept && cmd_code_i == CMD_OUTPUT_SETPOINT
		|=> $stable(setpt_q) && rsp_reject_o;
	endproperty
	a_reject: assert property (p_reject)
		else $error("Bad setpoint stored");

	// Start decision; polarity bit picks active-high pin sense
	always_comb begin
		pin_on = cfg[PIN_POLARITY_BIT] ? onoff_pin_i : !onoff_pin_i;
		bus_on = cfg[CMD_RESPOND_BIT] ? run_ctrl_q[ON_BIT] : 1'b1;
		run_d = 1'b1;
		if (cfg[PIN_REQUIRED_BIT])
			run_d = pin_on;
		if (cfg[POWER_UP_RULE_BIT])
			run_d = run_d && bus_on;
		else
			run_d = bus_on;
	end

	property p_pin_gate;
		@(posedge clk_i) disable iff (!reset_n_i)
		!onoff_pin_i |=> !output_enable_o;
	endproperty
	a_pin_gate: assert property (p_pin_gate)
		else $error("Output enabled with pin low");

	property p_on_bit;
		@(posedge clk_i) disable iff (!reset_n_i)
		onoff_pin_i && cmd_respond_q && !run_ctrl_q[ON_BIT]
		|=> !output_enable_o;
	endproperty
	a_on_bit: assert property (p_on_bit)
		else $error("Output enabled with on bit clear");

	property p_ignore;
		@(posedge clk_i) disable iff (!reset_n_i)
		onoff_pin_i && !cmd_respond_q |=> output_enable_o;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("On bit not ignored");

	// Unlisted patterns fall back to the nominal setpoint
	always_comb begin
		mg = run_ctrl_q[MARGIN_HI:MARGIN_LO];
		tgt_d = setpt_q;
		if (mg == MARGIN_LOW_PAT)
			tgt_d = mlo_q;
		else if (mg == MARGIN_HIGH_PAT)
			tgt_d = mhi_q;
	end

	property p_margin;
		@(posedge clk_i) disable iff (!reset_n_i)
		(mg == MARGIN_HIGH_PAT) ##1 (mg == MARGIN_HIGH_PAT)
		|-> target_vout_o == $past(mhi_q);
	endproperty
	a_margin: assert property (p_margin)
		else $error("Margin high not applied");

	property p_margin_low;
		@(posedge clk_i) disable iff (!reset_n_i)
		(mg == MARGIN_LOW_PAT) ##1 (mg == MARGIN_LOW_PAT)
		|-> target_vout_o == $past(mlo_q) && margin_active_o;
	endproperty
	a_margin_low: assert property (p_margin_low)
		else $error("Margin low not applied");

	property p_margin_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		(run_ctrl_q[MARGIN_HI:MARGIN_HI-1] == 2'b00)
		##1 (run_ctrl_q[MARGIN_HI:MARGIN_HI-1] == 2'b00)
		|-> target_vout_o == $past(setpt_q) && !margin_active_o;
	endproperty
	a_margin_off: assert property (p_margin_off)
		else $error("Margining not off");

	// Wraps on overflow; the offset is small against full scale
	assign vout_corr = vout_adc_i + vout_offset_cal_i;

	always_comb begin
		rd = 16'h0000;
		known = 1'b1;
		unique case (cmd_code_i)
			CMD_OUTPUT_RUN_CONTROL: rd = {8'h00, run_ctrl_q};
			CMD_POWER_SWITCH_CONFIG: rd = {11'h000, cfg};
			CMD_OUTPUT_MODE: rd = {8'h00, OUTPUT_MODE_VAL};
			CMD_OUTPUT_SETPOINT: rd = setpt_q;
			CMD_MARGIN_UPPER_LEVEL: rd = mhi_q;
			CMD_MARGIN_LOWER_LEVEL: rd = mlo_q;
			CMD_INPUT_TURN_ON_THRESHOLD: rd = on_th_q;
			CMD_INPUT_TURN_OFF_THRESHOLD: rd = off_th_q;
			CMD_STARTUP_DELAY_TIME: rd = delay_q;
			CMD_STARTUP_RAMP_TIME: rd = ramp_q;
			CMD_OUTPUT_VOLTAGE_READING: rd = vout_corr;
			CMD_INPUT_VOLTAGE_READING: rd = {EXP_UVLO, 1'b0,
				vin_adc_i[9:0]};
			CMD_OUTPUT_READING_OFFSET_CAL: rd = vout_offset_cal_i;
			CMD_INPUT_READING_OFFSET_CAL: rd = {EXP_UVLO,
				vin_offset_cal_i[10:0]};
			CMD_INPUT_READING_GAIN_CAL: rd = vin_gain_cal_i;
			default: known = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= 16'h0000;
			rsp_reject_o <= 1'b0;
		end else begin
			rsp_valid_o <= cmd_valid_i;
			rsp_rdata_o <= (cmd_valid_i && !cmd_write_i) ? rd : 16'h0000;
			rsp_reject_o <= cmd_valid_i
				&& (cmd_write_i ? !accept : !known);
		end
	end

	property p_read_vin;
		@(posedge clk_i) disable iff (!reset_n_i)
		cmd_valid_i && !cmd_write_i
		&& cmd_code_i == CMD_INPUT_VOLTAGE_READING
		|=> rsp_rdata_o[EXP_HI:EXP_LO] == EXP_UVLO
		&& !rsp_rdata_o[MANT_SIGN];
	endproperty
	a_read_vin: assert property (p_read_vin)
		else $error("Input reading format broken");

	property p_vout_mode;
		@(posedge clk_i) disable iff (!reset_n_i)
		cmd_valid_i && !cmd_write_i && cmd_code_i == CMD_OUTPUT_MODE
		|=> rsp_rdata_o == {8'h00, OUTPUT_MODE_VAL};
	endproperty
	a_vout_mode: assert property (p_vout_mode)
		else $error("Mode reading wrong");

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			nvm_store_o <= 1'b0;
		end else begin
			nvm_store_o <= wr && cmd_code_i == CMD_STORE_DEFAULT_ALL;
		end
	end

	property p_store;
		@(posedge clk_i) disable iff (!reset_n_i)
		nvm_store_o |-> $past(cmd_code_i) == CMD_STORE_DEFAULT_ALL;
	endproperty
	a_store: assert property (p_store)
		else $error("Store without command");

	property p_store_only;
		@(posedge clk_i) disable iff (!reset_n_i)
		!(wr && cmd_code_i == CMD_STORE_DEFAULT_ALL) |=> !nvm_store_o;
	endproperty
	a_store_only: assert property (p_store_only)
		else $error("Store pulse without store write");

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			output_enable_o <= 1'b0;
			target_vout_o <= SETPOINT_RST;
			margin_active_o <= 1'b0;
			on_thresh_o <= ON_THRESH_RST;
			off_thresh_o <= OFF_THRESH_RST;
			delay_time_o <= DELAY_RST;
			ramp_time_o <= RAMP_RST;
		end else begin
			output_enable_o <= run_d;
			target_vout_o <= tgt_d;
			margin_active_o <= mg == MARGIN_LOW_PAT || mg == MARGIN_HIGH_PAT;
			on_thresh_o <= on_th_q;
			off_thresh_o <= off_th_q;
			delay_time_o <= delay_q;
			ramp_time_o <= ramp_q;
		end
	end

endmodule : pmc_cmd_handler
`default_nettype wire

/* File: logic/pmc_pkg.sv */
// Package of command codes, field positions, limits and reset values
package pmc_pkg;
	// Command codes follow the public PMBus command numbering
	localparam logic [7:0] CMD_OUTPUT_RUN_CONTROL = 8'h01;
	localparam logic [7:0] CMD_POWER_SWITCH_CONFIG = 8'h02;
	localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
	localparam logic [7:0] CMD_OUTPUT_MODE = 8'h20;
	localparam logic [7:0] CMD_OUTPUT_SETPOINT = 8'h21;
	localparam logic [7:0] CMD_MARGIN_UPPER_LEVEL = 8'h25;
	localparam logic [7:0] CMD_MARGIN_LOWER_LEVEL = 8'h26;
	localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD = 8'h35;
	localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD = 8'h36;
	localparam logic [7:0] CMD_STARTUP_DELAY_TIME = 8'h60;
	localparam logic [7:0] CMD_STARTUP_RAMP_TIME = 8'h61;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING = 8'h8b;
	localparam logic [7:0] CMD_OUTPUT_READING_OFFSET_CAL = 8'hd0;
	localparam logic [7:0] CMD_INPUT_READING_OFFSET_CAL = 8'hd1;
	localparam logic [7:0] CMD_INPUT_READING_GAIN_CAL = 8'hd2;
	// Field positions
	localparam int ON_BIT = 7;
	localparam int MARGIN_HI = 5;
	localparam int MARGIN_LO = 2;
	localparam int POWER_UP_RULE_BIT = 4;
	localparam int CMD_RESPOND_BIT = 3;
	localparam int PIN_REQUIRED_BIT = 2;
	localparam int PIN_POLARITY_BIT = 1;
	localparam int PIN_ACTION_BIT = 0;
	localparam int EXP_HI = 15;
	localparam int EXP_LO = 11;
	localparam int MANT_SIGN = 10;
	// Margin patterns on bits 5..2
	localparam logic [3:0] MARGIN_LOW_PAT = 4'h6;
	localparam logic [3:0] MARGIN_HIGH_PAT = 4'ha;
	// Fixed exponents, five bit two's complement
	localparam logic [4:0] EXP_UVLO = 5'h1d;
	localparam logic [4:0] EXP_TIME = 5'h1f;
	localparam logic [7:0] OUTPUT_MODE_VAL = 8'h14;
	// Ranges in mantissa counts
	localparam logic [10:0] UVLO_MIN = 11'h100;
	localparam logic [10:0] UVLO_MAX = 11'h170;
	localparam logic [10:0] UVLO_HYST = 11'h010;
	localparam logic [10:0] DELAY_MIN = 11'h014;
	localparam logic [10:0] RAMP_MIN = 11'h01e;
	localparam logic [10:0] TIME_MAX = 11'h3e8;
	localparam logic [15:0] SETPOINT_MIN = 16'h819a;
	localparam logic [15:0] SETPOINT_MAX = 16'hd333;
	// Reset values
	localparam logic [7:0] RUN_CONTROL_RST = 8'h80;
	localparam logic [4:0] SWITCH_CONFIG_RST = 5'h1f;
	localparam logic [15:0] ON_THRESH_RST = 16'he920;
	localparam logic [15:0] OFF_THRESH_RST = 16'he910;
	localparam logic [15:0] DELAY_RST = 16'hf814;
	localparam logic [15:0] RAMP_RST = 16'hf81e;
	localparam logic [15:0] SETPOINT_RST = 16'hc000;
	localparam logic [15:0] MARGIN_UP_RST = 16'hc99a;
	localparam logic [15:0] MARGIN_DN_RST = 16'hb666;
endpackage : pmc_pkg

/* File: sim/pmc_host_model.sv */
// Host model issuing one command at a time on the command port
`timescale 1ns/10ps
`default_nettype none
module pmc_host_model (
	input wire logic clk_i,
	input wire logic rsp_valid_i,
	input wire logic [15:0] rsp_rdata_i,
	input wire logic rsp_reject_i,
	output logic cmd_valid_o,
	output logic cmd_write_o,
	output logic [7:0] cmd_code_o,
	output logic [15:0] cmd_wdata_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	// Whole words in the fixed formats; caller orders thresholds
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, output logic [15:0] rd,
		output logic rj, output logic ok);
		@(negedge clk_i);
		cmd_valid_o = 1'b1;
		cmd_write_o = w;
		cmd_code_o = c;
		cmd_wdata_o = d;
		@(negedge clk_i);
		cmd_valid_o = 1'b0;
		ok = (rsp_valid_i === 1'b1);
		rd = rsp_rdata_i;
		rj = rsp_reject_i;
		// Released lines must not keep a stale value
		cmd_write_o = ~w;
		cmd_code_o = ~c;
		cmd_wdata_o = ~d;
	endtask : xfer
endmodule : pmc_host_model
`default_nettype wire

/* File: sim/tb.sv */
// Testbench for the command handler
`timescale 1ns/10ps
`default_nettype none
module tb;
	import pmc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cv, cw, rv, rj, oe, ma, st;
	logic pin = 1'b1;
	logic [7:0] code;
	logic [15:0] wd, rd, tv, ont, oft, dly, rmp;
	logic [15:0] avo = 16'h1000;
	logic [15:0] cvo = 16'hfff0;
	logic [10:0] avi = 11'h7ff;
	logic [15:0] cvi = 16'hfc01;
	logic [15:0] cg = 16'h2000;
	int error_cnt = 0;
	int n_tests = 0;
	// Code, word, refused, expected stored value
	localparam logic [43:0] TBL [19] = '{
		44'h36_e900_0_e900, 44'h36_e8ff_1_e900, 44'h36_f100_1_e900,
		44'h35_e970_0_e970, 44'h35_e971_1_e970, 44'h35_ec00_1_e970,
		44'h36_e960_0_e960, 44'h60_fbe8_0_fbe8, 44'h60_fbe9_1_fbe8,
		44'h60_f813_1_fbe8, 44'h60_f814_0_f814, 44'h60_e814_1_f814,
		44'h61_f81d_1_f81e, 44'h61_fbe8_0_fbe8, 44'h61_fbe9_1_fbe8,
		44'h21_819a_0_819a, 44'h21_8199_1_819a, 44'h21_d334_1_819a,
		44'h21_d333_0_d333};
	always #4 clk_i = ~clk_i;
	pmc_host_model host (.clk_i(clk_i), .rsp_valid_i(rv),
		.rsp_rdata_i(rd), .rsp_reject_i(rj), .cmd_valid_o(cv),
		.cmd_write_o(cw), .cmd_code_o(code), .cmd_wdata_o(wd));
	pmc_cmd_handler DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.cmd_valid_i(cv), .cmd_write_i(cw), .cmd_code_i(code),
		.cmd_wdata_i(wd), .onoff_pin_i(pin), .vout_adc_i(avo),
		.vin_adc_i(avi), .vout_offset_cal_i(cvo),
		.vin_offset_cal_i(cvi), .vin_gain_cal_i(cg),
		.rsp_valid_o(rv), .rsp_rdata_o(rd), .rsp_reject_o(rj),
		.output_enable_o(oe), .target_vout_o(tv),
		.margin_active_o(ma), .on_thresh_o(ont), .off_thresh_o(oft),
		.delay_time_o(dly), .ramp_time_o(rmp), .nvm_store_o(st));
	task automatic check(input string nm, input logic [15:0] s, x);
		n_tests++;
		if (s !== x) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	// Waits one more cycle so settings and enable have landed
	task automatic op(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic xr, input logic [15:0] xd);
		logic [15:0] r;
		logic j, ok;
		host.xfer(w, c, d, r, j, ok);
		check("rsp_valid_o", {15'h0, ok}, 16'h1);
		check("rsp_reject_o", {15'h0, j}, {15'h0, xr});
		if (!xr)
			check("rsp_rdata_o", r, xd);
		check("nvm_store_o", {15'h0, st},
			{15'h0, w && c == CMD_STORE_DEFAULT_ALL});
		@(negedge clk_i);
	endtask : op
	function automatic logic [15:0] port_of(input logic [7:0] c);
		case (c)
			CMD_INPUT_TURN_ON_THRESHOLD: return ont;
			CMD_INPUT_TURN_OFF_THRESHOLD: return oft;
			CMD_STARTUP_DELAY_TIME: return dly;
			CMD_STARTUP_RAMP_TIME: return rmp;
			default: return tv;
		endcase
	endfunction : port_of
	initial begin
		logic [7:0] c;
		logic [15:0] d, x;
		logic r;
		logic [3:0] f;
		repeat (10) @(negedge clk_i);
		check("output_enable_o", {15'h0, oe}, 16'h0);
		reset_n_i = 1'b1;
		check("on_thresh_o", ont, ON_THRESH_RST);
		check("off_thresh_o", oft, OFF_THRESH_RST);
		check("delay_time_o", dly, DELAY_RST);
		check("ramp_time_o", rmp, RAMP_RST);
		check("target_vout_o", tv, SETPOINT_RST);
		repeat (2) @(negedge clk_i);
		check("output_enable_o", {15'h0, oe}, 16'h1);
		op(0, CMD_POWER_SWITCH_CONFIG, 16'h0, 0, 16'h001f);
		op(1, CMD_OUTPUT_RUN_CONTROL, 16'h0000, 0, 16'h0);
		check("output_enable_o", {15'h0, oe}, 16'h0);
		op(1, CMD_POWER_SWITCH_CONFIG, 16'h0000, 0, 16'h0);
		op(0, CMD_POWER_SWITCH_CONFIG, 16'h0, 0, 16'h0017);
		check("output_enable_o", {15'h0, oe}, 16'h1);
		op(1, CMD_POWER_SWITCH_CONFIG, 16'h00ff, 0, 16'h0);
		op(0, CMD_POWER_SWITCH_CONFIG, 16'h0, 0, 16'h001f);
		check("output_enable_o", {15'h0, oe}, 16'h0);
		op(1, CMD_OUTPUT_RUN_CONTROL, 16'h0080, 0, 16'h0);
		pin = 1'b0;
		repeat (2) @(negedge clk_i);
		check("output_enable_o", {15'h0, oe}, 16'h0);
		pin = 1'b1;
		foreach (TBL[i]) begin
			{c, d, f, x} = TBL[i];
			r = f[0];
			op(1, c, d, r, 16'h0);
			check("setting port", port_of(c), x);
			op(0, c, 16'h0, 0, x);
		end
		check("threshold spacing",
			{15'h0, ont[10:0] >= oft[10:0] + UVLO_HYST}, 16'h1);
		op(1, CMD_OUTPUT_RUN_CONTROL, 16'h00a8, 0, 16'h0);
		check("target_vout_o", tv, MARGIN_UP_RST);
		check("margin_active_o", {15'h0, ma}, 16'h1);
		op(1, CMD_MARGIN_UPPER_LEVEL, 16'hc800, 0, 16'h0);
		check("target_vout_o", tv, 16'hc800);
		op(1, CMD_OUTPUT_RUN_CONTROL, 16'h0098, 0, 16'h0);
		check("target_vout_o", tv, MARGIN_DN_RST);
		op(1, CMD_MARGIN_LOWER_LEVEL, 16'hb800, 0, 16'h0);
		check("target_vout_o", tv, 16'hb800);
		op(0, CMD_MARGIN_LOWER_LEVEL, 16'h0, 0, 16'hb800);
		op(0, CMD_MARGIN_UPPER_LEVEL, 16'h0, 0, 16'hc800);
		op(1, CMD_OUTPUT_RUN_CONTROL, 16'h0084, 0, 16'h0);
		check("target_vout_o", tv, 16'hd333);
		check("margin_active_o", {15'h0, ma}, 16'h0);
		op(0, CMD_OUTPUT_RUN_CONTROL, 16'h0, 0, 16'h0084);
		op(0, CMD_OUTPUT_MODE, 16'h0, 0, 16'h0014);
		op(0, CMD_OUTPUT_VOLTAGE_READING, 16'h0, 0, 16'h0ff0);
		op(0, CMD_INPUT_VOLTAGE_READING, 16'h0, 0, 16'hebff);
		op(0, CMD_OUTPUT_READING_OFFSET_CAL, 16'h0, 0, cvo);
		op(0, CMD_INPUT_READING_OFFSET_CAL, 16'h0, 0, 16'hec01);
		op(0, CMD_INPUT_READING_GAIN_CAL, 16'h0, 0, cg);
		op(0, 8'h99, 16'h0, 1, 16'h0);
		op(1, 8'h99, 16'h1234, 1, 16'h0);
		op(1, CMD_STORE_DEFAULT_ALL, 16'h0, 0, 16'h0);
		reset_n_i = 1'b0;
		@(negedge clk_i);
		check("output_enable_o", {15'h0, oe}, 16'h0);
		check("target_vout_o", tv, SETPOINT_RST);
		reset_n_i = 1'b1;
		op(0, CMD_OUTPUT_RUN_CONTROL, 16'h0, 0, {8'h00, RUN_CONTROL_RST});
		op(0, CMD_INPUT_TURN_ON_THRESHOLD, 16'h0, 0, ON_THRESH_RST);
		check("output_enable_o", {15'h0, oe}, 16'h1);
		summarize();
	end
endmodule : tb
`default_nettype wire
